// File: src/host_port_pkg.sv
// Constants, field layouts and carrier types of the host parallel port.
// Assumes one clock domain; host pins are sampled as synchronous inputs.
// Summary of operation
// - Passive 8-bit port, host makes every strobe.
// - One 16-bit input and one output buffer.
// - Pins show input full, output empty.
// - Status select reads status register mirroring flags.
// - Strobes honoured only while chip select low.
// - Strobe assertion raises enabled core interrupt.
// - Control bit 0 picks 16-bit or 8-bit.
// - 16-bit flags set after polarity-chosen last byte.
// - 8-bit mode uses low byte, flags every low byte access.
// - Control bit 1 picks strobe pair or rw.
// - Split strobes low-true; single strobe polarity bit 2.
// - Control bit 4 inverts flag pin polarity, except merged full pin.
// - Control bit 5 ORs flags onto full pin.
// - Control bit 7 inverts empty in status only.
// - Data byte decode by byte select and width.
// - Status reached when byte select equals polarity.
// - Status on host bus, bits 3 and 2.
package host_port_pkg;

  // Control register field positions
  localparam int CTL_WIDTH_SEL_BIT      = 0;
  localparam int CTL_PROTOCOL_SEL_BIT   = 1;
  localparam int CTL_STROBE_POL_BIT     = 2;
  localparam int CTL_BYTE_SEL_POL_BIT   = 3;
  localparam int CTL_FLAG_PIN_POL_BIT   = 4;
  localparam int CTL_FLAG_MERGE_BIT     = 5;
  localparam int CTL_STATUS_EMPTY_INV   = 7;

  // Status register field positions
  localparam int STAT_IN_FULL_BIT       = 3;
  localparam int STAT_OUT_EMPTY_BIT     = 2;

  // Reset values
  localparam logic [15:0] CTL_RESET      = 16'h0000;
  localparam logic [15:0] BUF_RESET      = 16'h0000;
  localparam logic        IN_FULL_RESET  = 1'b0;
  localparam logic        OUT_EMPTY_RESET = 1'b1;

  // Host-side pins, all sampled on i_clk
  typedef struct packed {
    logic       chip_sel_n;
    logic       in_strobe_n;
    logic       out_strobe_n;
    logic       read_write_n;
    logic       single_data_strobe;
    logic       byte_sel;
    logic       status_sel;
    logic [7:0] host_bus;
  } host_pins_t;

  // Byte target of a host access
  typedef enum logic [3:0] {
    TGT_NONE = 4'b0001,
    TGT_LOW  = 4'b0010,
    TGT_HIGH = 4'b0100,
    TGT_STAT = 4'b1000
  } target_t;

  // Host access sequencer
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } acc_state_t;

endpackage

// File: src/host_port.sv
// Host parallel port: buffers, flags, strobe decode and control register.
// Assumes host pins are synchronous to i_clk and the core drives the
// control register and buffer side through single-cycle strobes.
`timescale 1ns/1ps

module host_port
  import host_port_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire host_pins_t  i_host,
  output logic       [7:0] o_host_bus,
  output logic             o_host_bus_oe_n,
  output logic             o_in_buf_full,
  output logic             o_out_buf_empty,
  input  wire logic        i_ctrl_wr,
  input  wire logic [15:0] i_ctrl_wdata,
  output logic      [15:0] o_ctrl,
  output logic       [7:0] o_status,
  input  wire logic        i_core_in_rd,
  output logic      [15:0] o_in_data,
  input  wire logic        i_core_out_wr,
  input  wire logic [15:0] i_core_out_data,
  input  wire logic        i_irq_en_in,
  input  wire logic        i_irq_en_out,
  output logic             o_irq_in,
  output logic             o_irq_out
);

  // Byte target from status select, byte select and control bits
  // Reserved combinations decode to TGT_NONE, so they commit nothing
  // and read back as zero instead of aliasing onto a real byte.
  function automatic target_t decode_target(input logic stat_sel,
                                            input logic bsel,
                                            input logic [15:0] ctl);
    logic match;
    match = (bsel == ctl[CTL_BYTE_SEL_POL_BIT]);
    if (stat_sel) begin
      decode_target = match ? TGT_STAT : TGT_NONE;
    end else if (match) begin
      decode_target = TGT_LOW;
    end else if (ctl[CTL_WIDTH_SEL_BIT]) begin
      decode_target = TGT_HIGH;
    end else begin
      decode_target = TGT_NONE;
    end
  endfunction

  // Byte that completes a word transfer and sets the flag
  // Status accesses never complete a word, so they leave flags alone.
  // In 8-bit mode every low byte access completes the transfer.
  function automatic logic is_last_byte(input target_t tgt,
                                        input logic [15:0] ctl);
    if (!ctl[CTL_WIDTH_SEL_BIT]) begin
      is_last_byte = (tgt == TGT_LOW);
    end else if (ctl[CTL_BYTE_SEL_POL_BIT]) begin
      is_last_byte = (tgt == TGT_LOW);
    end else begin
      is_last_byte = (tgt == TGT_HIGH);
    end
  endfunction

  // Control register
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;

  // Data buffers, host to core and core to host
  logic [15:0] in_buf_reg;
  logic [15:0] in_buf_next;
  logic [15:0] out_buf_reg;
  logic [15:0] out_buf_next;

  // Raw buffer flags, before any pin polarity
  logic        in_full_reg;
  logic        in_full_next;
  logic        out_empty_reg;
  logic        out_empty_next;

  // Access sequencer with latched target and write byte
  acc_state_t  state_reg;
  acc_state_t  state_next;
  target_t     tgt_reg;
  target_t     tgt_next;
  logic [7:0]  wbyte_reg;
  logic [7:0]  wbyte_next;

  // Host bus drive
  logic [7:0]  bus_reg;
  logic [7:0]  bus_next;
  logic        oe_n_reg;
  logic        oe_n_next;

  // Flag pins after polarity and merge
  logic        pin_full_reg;
  logic        pin_full_next;
  logic        pin_empty_reg;
  logic        pin_empty_next;

  // Interrupt pulses toward the core
  logic        irq_in_reg;
  logic        irq_in_next;
  logic        irq_out_reg;
  logic        irq_out_next;

  // Combinational decode of the host pins
  logic [7:0]  status_byte;
  logic        wr_act;
  logic        rd_act;
  logic        ds_act;
  target_t     tgt_now;

  // Strobe decode for both protocols, gated by chip select
  // The chip select gate comes last so it overrides either protocol;
  // a host that ties chip select low gets every strobe honoured.
  // The split strobes are fixed low-true whatever bit 2 holds.
  always_comb begin
    ds_act = (i_host.single_data_strobe ==
              ctrl_reg[CTL_STROBE_POL_BIT]);
    if (ctrl_reg[CTL_PROTOCOL_SEL_BIT]) begin
      wr_act = ds_act && !i_host.read_write_n;
      rd_act = ds_act && i_host.read_write_n;
    end else begin
      wr_act = !i_host.in_strobe_n;
      rd_act = !i_host.out_strobe_n;
    end
    if (i_host.chip_sel_n) begin
      wr_act = 1'b0;
      rd_act = 1'b0;
    end
    tgt_now = decode_target(i_host.status_sel, i_host.byte_sel, ctrl_reg);
  end

  // Status byte as presented to the host
  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_IN_FULL_BIT] = in_full_reg;
    status_byte[STAT_OUT_EMPTY_BIT] =
      out_empty_reg ^ ctrl_reg[CTL_STATUS_EMPTY_INV];
  end

  // Access sequencer, buffers and flags
  always_comb begin
    state_next     = state_reg;
    tgt_next       = tgt_reg;
    wbyte_next     = wbyte_reg;
    in_buf_next    = in_buf_reg;
    out_buf_next   = out_buf_reg;
    in_full_next   = in_full_reg;
    out_empty_next = out_empty_reg;
    ctrl_next      = ctrl_reg;
    irq_in_next    = 1'b0;
    irq_out_next   = 1'b0;
    if (i_ctrl_wr) begin
      ctrl_next = i_ctrl_wdata;
    end
    // Core side clears; a host set below overrides in the same cycle
    if (i_core_in_rd) begin
      in_full_next = 1'b0;
    end
    if (i_core_out_wr) begin
      out_buf_next   = i_core_out_data;
      out_empty_next = 1'b0;
    end
    // Idle waits for a strobe and latches the target at its start.
    // Write samples the bus while the strobe stands and commits the
    // last byte seen once the strobe goes away.
    // Read holds the bus drive until the strobe goes away, then marks
    // the output buffer empty when the word is complete.
    case (state_reg)
      ST_IDLE: begin
        if (wr_act) begin
          state_next  = ST_WRITE;
          tgt_next    = tgt_now;
          wbyte_next  = i_host.host_bus;
          irq_in_next = i_irq_en_in;
        end else if (rd_act) begin
          state_next   = ST_READ;
          tgt_next     = tgt_now;
          irq_out_next = i_irq_en_out;
        end
      end
      ST_WRITE: begin
        if (wr_act) begin
          wbyte_next = i_host.host_bus;
        end else begin
          state_next = ST_IDLE;
          // Commit on strobe release
          // Late bus data is caught because the byte is resampled on
          // every cycle of the strobe, not only the first.
          if (tgt_reg == TGT_LOW) begin
            in_buf_next[7:0] = wbyte_reg;
          end else if (tgt_reg == TGT_HIGH) begin
            in_buf_next[15:8] = wbyte_reg;
          end
          if (is_last_byte(tgt_reg, ctrl_reg)) begin
            in_full_next = 1'b1;
          end
        end
      end
      ST_READ: begin
        // Empty is set only at release, so a slow host still reads
        // the byte before the core may refill the buffer.
        if (!rd_act) begin
          state_next = ST_IDLE;
          if (is_last_byte(tgt_reg, ctrl_reg)) begin
            out_empty_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Host bus drive during a read
  // The bus is driven only while a read strobe stands, so a write
  // that follows never meets the device still driving the bus.
  // Reserved targets drive zero rather than a stale byte.
  always_comb begin
    bus_next  = 8'h00;
    oe_n_next = 1'b1;
    if (rd_act && state_next == ST_READ) begin
      oe_n_next = 1'b0;
      case (tgt_next)
        TGT_LOW:  bus_next = out_buf_reg[7:0];
        TGT_HIGH: bus_next = out_buf_reg[15:8];
        TGT_STAT: bus_next = status_byte;
        default:  bus_next = 8'h00;
      endcase
    end
  end

  // Flag pins with polarity and merge options
  // The merged pin is always positive, ignoring the polarity bit.
  // The status invert bit never reaches the pins.
  always_comb begin
    if (ctrl_reg[CTL_FLAG_MERGE_BIT]) begin
      pin_full_next = in_full_reg | out_empty_reg;
    end else begin
      pin_full_next =
        in_full_reg ^ ctrl_reg[CTL_FLAG_PIN_POL_BIT];
    end
    pin_empty_next =
      out_empty_reg ^ ctrl_reg[CTL_FLAG_PIN_POL_BIT];
  end

  // State registers
  // Reset leaves the output buffer empty and the bus released.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg      <= CTL_RESET;
      in_buf_reg    <= BUF_RESET;
      out_buf_reg   <= BUF_RESET;
      in_full_reg   <= IN_FULL_RESET;
      out_empty_reg <= OUT_EMPTY_RESET;
      state_reg     <= ST_IDLE;
      tgt_reg       <= TGT_NONE;
      wbyte_reg     <= 8'h00;
      bus_reg       <= 8'h00;
      oe_n_reg      <= 1'b1;
      pin_full_reg  <= IN_FULL_RESET;
      pin_empty_reg <= OUT_EMPTY_RESET;
      irq_in_reg    <= 1'b0;
      irq_out_reg   <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      in_buf_reg    <= in_buf_next;
      out_buf_reg   <= out_buf_next;
      in_full_reg   <= in_full_next;
      out_empty_reg <= out_empty_next;
      state_reg     <= state_next;
      tgt_reg       <= tgt_next;
      wbyte_reg     <= wbyte_next;
      bus_reg       <= bus_next;
      oe_n_reg      <= oe_n_next;
      pin_full_reg  <= pin_full_next;
      pin_empty_reg <= pin_empty_next;
      irq_in_reg    <= irq_in_next;
      irq_out_reg   <= irq_out_next;
    end
  end

  // Host side outputs
  assign o_host_bus      = bus_reg;
  assign o_host_bus_oe_n = oe_n_reg;
  assign o_in_buf_full   = pin_full_reg;
  assign o_out_buf_empty = pin_empty_reg;

  // Core side outputs
  assign o_ctrl          = ctrl_reg;
  assign o_status        = status_byte;
  assign o_in_data       = in_buf_reg;
  assign o_irq_in        = irq_in_reg;
  assign o_irq_out       = irq_out_reg;

endmodule

// File: sim/host_port_properties.sv
// Checker for the host port, bound to every host_port instance.
// Assumes control changes only while the host is idle.
`timescale 1ns/1ps
module host_port_properties
  import host_port_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire host_pins_t  i_host,
  input wire logic  [7:0] o_host_bus,
  input wire logic        o_host_bus_oe_n,
  input wire logic        o_in_buf_full,
  input wire logic        o_out_buf_empty,
  input wire logic [15:0] o_ctrl,
  input wire logic  [7:0] o_status,
  input wire logic        i_core_in_rd,
  input wire logic        i_irq_en_in,
  input wire logic        o_irq_in,
  input wire logic        i_core_out_wr,
  input wire logic        i_irq_en_out,
  input wire logic        o_irq_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Read strobe in the selected protocol, and the raw empty flag
  logic rd;
  logic emp;
  assign rd = !i_host.chip_sel_n && (o_ctrl[1] ? i_host.read_write_n &&
    (i_host.single_data_strobe == o_ctrl[2]) : !i_host.out_strobe_n);
  assign emp = o_status[2] ^ o_ctrl[7];
  AST_CS_IDLE: assert property (i_host.chip_sel_n |=> o_host_bus_oe_n)
    else $error("bus driven while deselected");
  AST_READ_OE: assert property (rd |=> !o_host_bus_oe_n)
    else $error("read not answered");
  AST_STAT_RD: assert property (rd && i_host.status_sel &&
    (i_host.byte_sel == o_ctrl[3]) |=> o_host_bus == $past(o_status))
    else $error("status read wrong");
  AST_STAT_RSVD: assert property (o_status[7:4] == 4'h0 &&
    o_status[1:0] == 2'b00) else $error("status spare bits set");
  AST_FULL_PIN: assert property (!$past(o_ctrl[5]) |->
    o_in_buf_full == ($past(o_status[3]) ^ $past(o_ctrl[4])))
    else $error("full pin wrong");
  AST_MERGE: assert property ($past(o_ctrl[5]) |->
    o_in_buf_full == ($past(o_status[3]) | $past(emp)))
    else $error("merged pin wrong");
  AST_EMPTY_PIN: assert property (
    o_out_buf_empty == ($past(emp) ^ $past(o_ctrl[4])))
    else $error("empty pin wrong");
  AST_CLR_FULL: assert property (i_core_in_rd && i_host.chip_sel_n &&
    $past(i_host.chip_sel_n) && $past(i_host.chip_sel_n, 2) |=> !o_status[3])
    else $error("full flag not cleared");
  AST_IRQ: assert property (o_irq_in |->
    ($past(i_irq_en_in) && !$past(i_host.chip_sel_n)) ##1 !o_irq_in)
    else $error("bad interrupt pulse");
  AST_IRQ_OUT: assert property (o_irq_out |->
    ($past(i_irq_en_out) && !$past(i_host.chip_sel_n)) ##1 !o_irq_out)
    else $error("bad read interrupt pulse");
  AST_CLR_EMPTY: assert property (i_core_out_wr && i_host.chip_sel_n &&
    $past(i_host.chip_sel_n) && $past(i_host.chip_sel_n, 2) |=> !emp)
    else $error("empty flag not cleared");
  // Main scenarios
  cover property (o_irq_out);
  cover property (rd ##1 !o_host_bus_oe_n);
  cover property (o_irq_in);
  cover property (o_ctrl[5] && o_in_buf_full);
endmodule

bind host_port host_port_properties i_props (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_host(i_host), .o_host_bus(o_host_bus),
  .o_host_bus_oe_n(o_host_bus_oe_n), .o_in_buf_full(o_in_buf_full),
  .o_out_buf_empty(o_out_buf_empty), .o_ctrl(o_ctrl),
  .o_status(o_status), .i_core_in_rd(i_core_in_rd),
  .i_irq_en_in(i_irq_en_in), .o_irq_in(o_irq_in),
  .i_core_out_wr(i_core_out_wr), .i_irq_en_out(i_irq_en_out),
  .o_irq_out(o_irq_out));

// File: sim/host_model.sv
// Host model: makes every strobe of the parallel port.
// Assumes the bench sets protocol and strobe polarity beforehand.
`timescale 1ns/1ps
module host_model
  import host_port_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_proto,
  input  wire logic       i_ds_pol,
  input  wire logic [7:0] i_bus,
  output host_pins_t      o_pins
);
  // Deselected, split strobes inactive, single data strobe low
  initial o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
  // One byte access, held two cycles
  task automatic acc(input logic cs_n, rd, ss, bs,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    #1;
    o_pins.chip_sel_n = cs_n;
    o_pins.status_sel = ss;
    o_pins.byte_sel = bs;
    o_pins.read_write_n = rd;
    o_pins.host_bus = rd ? ~d : d;               // Complement of d driven on reads
    if (i_proto) o_pins.single_data_strobe = i_ds_pol;
    else if (rd) o_pins.out_strobe_n = 1'b0;
    else o_pins.in_strobe_n = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    q = i_bus;
    o_pins.chip_sel_n = 1'b1;
    o_pins.in_strobe_n = 1'b1;
    o_pins.out_strobe_n = 1'b1;
    o_pins.single_data_strobe = ~i_ds_pol;
    o_pins.host_bus = ~o_pins.host_bus;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
endmodule

// File: sim/tb_top.sv
// Bench for the host port: host model, core pulses, flag and data checks.
// Assumes one 250 MHz clock; the bench plays the core side.
`timescale 1ns/1ps
module tb_top;
  import host_port_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ow = 0;
  logic        proto = 0, pol = 0, oe_n, full, empty, irq_in;
  logic        en_in = 1, en_out = 1, irq_out;
  int          n_iro = 0;
  logic [15:0] wd = 16'h0000, ctrl, in_data;
  logic  [7:0] bus, st, q;
  host_pins_t  pins;
  int          n_errors = 0, tests_run = 0, n_irq = 0, k;
  host_model i_host_model (.i_clk(clk), .i_proto(proto), .i_ds_pol(pol),
    .i_bus(bus), .o_pins(pins));
  host_port i_host_port (.i_clk(clk), .i_rst_n(rst_n), .i_host(pins),
    .o_host_bus(bus), .o_host_bus_oe_n(oe_n), .o_in_buf_full(full),
    .o_out_buf_empty(empty), .i_ctrl_wr(wr), .i_ctrl_wdata(wd),
    .o_ctrl(ctrl), .o_status(st), .i_core_in_rd(rd), .o_in_data(in_data),
    .i_core_out_wr(ow), .i_core_out_data(wd), .i_irq_en_in(en_in),
    .i_irq_en_out(en_out), .o_irq_in(irq_in), .o_irq_out(irq_out));
  always #2 clk = ~clk;
  always @(posedge clk) if (irq_in === 1'b1) n_irq <= n_irq + 1;
  always @(posedge clk) if (irq_out === 1'b1) n_iro <= n_iro + 1;
  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sts(input logic [7:0] e);
    chk({8'h00, st}, {8'h00, e});
  endtask
  task automatic pinz(input logic [1:0] e);
    chk({14'h0000, full, empty}, {14'h0000, e});
  endtask
  // Core pulse: 0 loads control, 1 reads input, 2 writes output
  task automatic core(input int kind, input logic [15:0] v);
    @(posedge clk);
    #1;
    wr = (kind == 0);
    rd = (kind == 1);
    ow = (kind == 2);
    wd = v;
    if (kind == 0) {pol, proto} = v[2:1];
    @(posedge clk);
    #1;
    {wr, rd, ow} = 3'b000;
    @(posedge clk);
    #1;
  endtask
  task automatic w(input logic cs_n, bs, input logic [7:0] d);
    i_host_model.acc(cs_n, 1'b0, 1'b0, bs, d, q);
  endtask
  task automatic r(input logic ss, bs, input logic [7:0] e);
    i_host_model.acc(1'b0, 1'b1, ss, bs, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic conclude;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    chk(ctrl, CTL_RESET);
    pinz(2'b01);
    k = n_irq;
    w(1'b1, 1'b0, 8'h3c);
    chk(16'(n_irq - k), 16'h0000);
    sts(8'h04);
    w(1'b0, 1'b0, 8'h5a);
    chk(16'(n_irq - k), 16'h0001);
    chk(in_data, 16'h005a);
    pinz(2'b11);
    r(1'b1, 1'b0, 8'h0c);
    r(1'b1, 1'b1, 8'h00);
    core(1, 16'h0000);
    sts(8'h04);
    w(1'b0, 1'b1, 8'h77);
    sts(8'h04);
    core(0, 16'h0001);
    w(1'b0, 1'b0, 8'h34);
    sts(8'h04);
    w(1'b0, 1'b1, 8'h12);
    chk(in_data, 16'h1234);
    sts(8'h0c);
    core(1, 16'h0000);
    core(0, 16'h0009);
    w(1'b0, 1'b0, 8'hab);
    sts(8'h04);
    w(1'b0, 1'b1, 8'hcd);
    chk(in_data, 16'habcd);
    core(1, 16'h0000);
    core(2, 16'hbeef);
    pinz(2'b00);
    r(1'b0, 1'b0, 8'hbe);
    sts(8'h00);
    r(1'b0, 1'b1, 8'hef);
    sts(8'h04);
    core(0, 16'h0002);
    w(1'b0, 1'b0, 8'h11);
    chk({8'h00, in_data[7:0]}, 16'h0011);
    core(1, 16'h0000);
    core(0, 16'h0006);
    core(2, 16'h0077);
    r(1'b0, 1'b0, 8'h77);
    sts(8'h04);
    core(0, 16'h0010);
    pinz(2'b10);
    core(0, 16'h0020);
    pinz(2'b11);
    core(0, 16'h0080);
    r(1'b1, 1'b0, 8'h00);
    pinz(2'b01);
    chk(16'(n_iro), 16'h0006);
    en_in = 0;
    en_out = 0;
    k = n_irq;
    w(1'b0, 1'b0, 8'h22);
    chk(16'(n_irq - k), 16'h0000);
    r(1'b1, 1'b0, 8'h08);
    chk(16'(n_iro), 16'h0006);
    conclude();
  end
endmodule
